// >>> testbench/t1m_line_model.sv
`timescale 1ns/100ps
module t1m_line_model (
  input logic aclk, // Clock
  output logic rx_bit_stb, // Bit present
  output logic rx_pos, // Positive mark
  output logic rx_neg // Negative mark
);
  logic pol = 1'b0;
  initial
  begin
    rx_bit_stb = 1'b0;
    rx_pos = 1'b0;
    rx_neg = 1'b0;
  end
  task automatic send(input logic p, input logic n);
    rx_bit_stb <= 1'b1;
    rx_pos <= p;
    rx_neg <= n;
    @(posedge aclk);
  endtask
  task automatic idle;
    rx_bit_stb <= 1'b0;
    rx_pos <= 1'b0;
    rx_neg <= 1'b0;
    @(posedge aclk);
  endtask
  // Ones alternate polarity, so plain traffic never holds a violation
  task automatic bits(input int cnt, input logic one);
    repeat (cnt)
    begin
      if (one)
        pol = ~pol;
      send(one & pol, one & ~pol);
    end
    idle;
  endtask
  // Zero substitution word 000VB0VB after the last mark
  task automatic b8zs;
    repeat (3) send(1'b0, 1'b0);
    send(pol, ~pol);
    send(~pol, pol);
    send(1'b0, 1'b0);
    send(~pol, pol);
    send(pol, ~pol);
    idle;
  endtask
endmodule

// >>> testbench/test_t1_rx_monitor_milliwatt.sv
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module test_t1_rx_monitor_milliwatt;
  import t1m_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic tx_bit_stb = 1'b0, tx_bit = 1'b1, fbit_stb = 1'b0, fbit_err = 1'b0;
  logic resync_stb = 1'b0, resync_moved = 1'b0, fs12_stb = 1'b0, fs12_val = 1'b0;
  logic ch_stb = 1'b0, fdl_stb = 1'b0, fdl_bit = 1'b0, loss_of_frame_flag = 1'b0;
  logic [4:0] ch_num = 5'h00;
  logic [7:0] ch_byte = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, bp_valid, irq;
  logic blue_alarm_flag, yellow_alarm_flag, red_alarm_flag, rx_bit_stb, rx_pos, rx_neg;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata;
  logic [4:0] bp_num;
  logic [7:0] bp_byte, rv;
  int n_fail = 0;
  int samples_checked = 0;

  always #50 aclk = ~aclk;

  t1m_line_model u_line (.aclk, .rx_bit_stb, .rx_pos, .rx_neg);

  t1m_top #(.BLUE_CYC(200)) u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .rx_bit_stb, .rx_pos, .rx_neg, .tx_bit_stb, .tx_bit,
    .fbit_stb, .fbit_err, .resync_stb, .resync_moved, .fs12_stb, .fs12_val, .ch_stb,
    .ch_num, .ch_byte, .fdl_stb, .fdl_bit, .loss_of_frame_flag, .bp_valid, .bp_num,
    .bp_byte, .blue_alarm_flag, .yellow_alarm_flag, .red_alarm_flag, .irq);

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    ta = 1'b1;
    tw = 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ta || tw)
    begin
      @(posedge aclk);
      ta = ta && !awready;
      tw = tw && !wready;
      awvalid <= ta;
      wvalid <= tw;
    end
    while (!bvalid) @(posedge aclk);
    rr = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rv = rdata[7:0];
    rr = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Read events, clear them all, confirm they are gone
  task automatic ev(input logic [7:0] e);
    rd(8'h40);
    `CHK(rv, e)
    wr(8'h40, 8'hff);
    rd(8'h40);
    `CHK(rv, 8'h00)
  endtask

  task automatic chan(input logic [4:0] n, input logic [7:0] b, input logic [7:0] e);
    ch_stb <= 1'b1;
    ch_num <= n;
    ch_byte <= b;
    @(posedge aclk);
    ch_stb <= 1'b0;
    @(posedge aclk);
    `CHK({bp_valid, bp_num, bp_byte}, {1'b1, n, e})
  endtask

  task automatic fb(input logic v);
    fbit_stb <= 1'b1;
    fbit_err <= v;
    @(posedge aclk);
    fbit_stb <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rs(input logic v);
    resync_stb <= 1'b1;
    resync_moved <= v;
    @(posedge aclk);
    resync_stb <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic f12(input logic v);
    fs12_stb <= 1'b1;
    fs12_val <= v;
    @(posedge aclk);
    fs12_stb <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_regs;
    logic [7:0] ad [6] = '{8'h30, 8'h34, 8'h38, 8'h40, 8'h44, 8'h48};
    foreach (ad[i])
    begin
      rd(ad[i]);
      `CHK({rr, rv}, {RESP_OKAY, RST_REG})
    end
    wr(8'h34, 8'ha5);
    wstrb <= 4'h0;
    wr(8'h34, 8'h5a);
    wstrb <= 4'hf;
    rd(8'h34);
    `CHK(rv, 8'ha5)
    wr(8'h31, 8'h11);
    `CHK(rr, RESP_SLVERR)
    rd(8'h50);
    `CHK({rr, rv}, {RESP_SLVERR, 8'h00})
    wr(8'h34, 8'h00);
  endtask

  // Two blocks of 256 bytes: 254 zeros in bit 2, then 253
  task automatic t_bit2;
    logic [7:0] v;
    for (int b = 2; b < 4; b++)
    begin
      for (int i = 0; i < 256; i++)
      begin
        v = (i < b) ? 8'h40 : 8'h00;
        chan(5'(i % 22 + 1), v, v);
      end
      repeat (3) @(posedge aclk);
      `CHK(yellow_alarm_flag, 1'(b == 2))
    end
  endtask

  task automatic t_mw;
    logic [7:0] v;
    wr(8'h30, 8'h01);
    wr(8'h38, 8'h80);
    for (int k = 0; k < 9; k++)
      for (int c = 0; c < 24; c++)
      begin
        v = 8'(c * 9 + k);
        chan(5'(c), v, (c == 0 || c == 23) ? MW_PAT[k % 8] : v);
      end
  endtask

  task automatic t_zero;
    wr(8'h44, 8'h10);
    u_line.bits(7, 1'b0);
    u_line.bits(1, 1'b1);
    ev(8'h00);
    u_line.bits(8, 1'b0);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b1)
    u_line.bits(1, 1'b1);
    ev(8'h10);
    `CHK(irq, 1'b0)
    u_line.bits(16, 1'b0);
    u_line.bits(50, 1'b1);
    ev(8'h98);
  endtask

  task automatic t_tx;
    tx_bit_stb <= 1'b1;
    tx_bit <= 1'b0;
    repeat (16) @(posedge aclk);
    tx_bit <= 1'b1;
    repeat (30) @(posedge aclk);
    tx_bit_stb <= 1'b0;
    @(posedge aclk);
    ev(8'h40);
    // Ones sixteen apart: no long run, but a sparse 24-bit window
    tx_bit_stb <= 1'b1;
    repeat (4)
    begin
      tx_bit <= 1'b1;
      @(posedge aclk);
      tx_bit <= 1'b0;
      repeat (15) @(posedge aclk);
    end
    tx_bit_stb <= 1'b0;
    tx_bit <= 1'b1;
    @(posedge aclk);
    ev(8'h40);
  endtask

  task automatic fdl(input logic [15:0] p);
    for (int i = 15; i >= 0; i--)
    begin
      fdl_stb <= 1'b1;
      fdl_bit <= p[i];
      @(posedge aclk);
    end
    fdl_stb <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic t_esf;
    wr(8'h48, 8'h01);
    repeat (15) fdl(16'h00ff);
    `CHK(yellow_alarm_flag, 1'b0)
    fdl(16'h00ff);
    `CHK(yellow_alarm_flag, 1'b1)
    repeat (2) fdl(16'hffff);
    repeat (13) fdl(16'h00ff);
    `CHK(yellow_alarm_flag, 1'b1)
    fdl(16'h00ff);
    `CHK(yellow_alarm_flag, 1'b0)
  endtask

  task automatic t_frame;
    fb(1'b1);
    ev(8'h01);
    repeat (6) fb(1'b0);
    fb(1'b1);
    repeat (4) fb(1'b0);
    fb(1'b1);
    ev(8'h05);
    rs(1'b0);
    ev(8'h00);
    rs(1'b1);
    ev(8'h20);
    u_line.b8zs;
    u_line.bits(4, 1'b1);
    ev(8'h02);
  endtask

  task automatic t_alarm;
    u_line.bits(191, 1'b0);
    repeat (3) @(posedge aclk);
    `CHK(red_alarm_flag, 1'b0)
    u_line.bits(1, 1'b0);
    repeat (3) @(posedge aclk);
    `CHK(red_alarm_flag, 1'b1)
    u_line.bits(112, 1'b1);
    repeat (3) @(posedge aclk);
    `CHK(red_alarm_flag, 1'b0)
    wr(8'h48, 8'h02);
    f12(1'b1);
    `CHK(yellow_alarm_flag, 1'b0)
    f12(1'b1);
    `CHK(yellow_alarm_flag, 1'b1)
    f12(1'b0);
    `CHK(yellow_alarm_flag, 1'b1)
    f12(1'b0);
    `CHK(yellow_alarm_flag, 1'b0)
  endtask

  task automatic t_blue;
    loss_of_frame_flag <= 1'b1;
    u_line.bits(450, 1'b0);
    `CHK(blue_alarm_flag, 1'b0)
    u_line.bits(450, 1'b1);
    `CHK(blue_alarm_flag, 1'b1)
    rd(8'h4c);
    `CHK(rv, 8'h09)
    repeat (11)
    begin
      u_line.bits(40, 1'b1);
      u_line.bits(1, 1'b0);
    end
    `CHK(blue_alarm_flag, 1'b1)
    repeat (20)
    begin
      u_line.bits(24, 1'b1);
      u_line.bits(1, 1'b0);
    end
    `CHK(blue_alarm_flag, 1'b0)
  endtask

  task give_verdict;
    $display("mismatches %0d comparisons %0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #2000000;
    n_fail++;
    give_verdict;
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_bit2;
    t_mw;
    t_zero;
    t_tx;
    t_frame;
    t_alarm;
    t_esf;
    t_blue;
    give_verdict;
  end
endmodule

// >>> verilog/t1m_pkg.sv
package t1m_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_MW1 = 6'h0c;
  localparam logic [5:0] IDX_MW2 = 6'h0d;
  localparam logic [5:0] IDX_MW3 = 6'h0e;
  localparam logic [5:0] IDX_EVT = 6'h10;
  localparam logic [5:0] IDX_MASK = 6'h11;
  localparam logic [5:0] IDX_CTRL = 6'h12;
  localparam logic [5:0] IDX_ALRM = 6'h13;
  localparam logic [7:0] RST_REG = 8'h00;
  // Control register fields
  localparam int CTRL_ESF = 0;
  localparam int CTRL_F12 = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_NS = 100;
  localparam int BLUE_WIN_NS = 3000000;
  localparam int BLUE_WIN_CYC = BLUE_WIN_NS / CLK_NS;
  localparam logic [2:0] BLUE_MAXZ = 3'h5;
  localparam logic [7:0] ZRUN_8 = 8'h08;
  localparam logic [7:0] ZRUN_16 = 8'h10;
  localparam logic [7:0] RED_SET = 8'hc0;
  localparam logic [6:0] RED_WIN = 7'h70;
  localparam logic [3:0] RED_ONES = 4'he;
  localparam logic [8:0] YEL_MIN = 9'h0fe;
  localparam logic [4:0] FDL_RUN = 5'h10;
  localparam logic [4:0] FDL_CLR_MAX = 5'h0e;
  localparam logic [15:0] FDL_PAT = 16'h00ff;
  localparam logic [4:0] PD_MAXZ = 5'h0f;
  localparam int PD_NMAX = 23;
  localparam logic [4:0] LAST_CH = 5'h17;
  localparam logic [7:0] B8_PRI = 8'h11;
  localparam logic [7:0] B8_ALT = 8'h0a;
  localparam logic [7:0] MW_PAT [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e,
                                       8'h9e, 8'h8b, 8'h8b, 8'h9e};

  typedef struct packed {
    logic rx_density_violation_evt;
    logic tx_density_violation_evt;
    logic alignment_change_evt;
    logic z8;
    logic z16;
    logic severe_framing_err_evt;
    logic b8zs;
    logic framing_bit_error_evt;
  } t1m_evt_type;

  typedef struct packed {
    logic lof;
    logic red;
    logic yellow;
    logic blue;
  } t1m_alarm_type;

  typedef enum logic [1:0] {
    RED_OK = 2'b00,
    RED_LOST = 2'b01,
    RED_CHK = 2'b10
  } t1m_red_type;
endpackage

// >>> verilog/t1m_top.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
module t1m_pdv
  import t1m_pkg::*;
#(
  parameter int NMAX = PD_NMAX
) (
  input logic aclk, // Clock
  input logic aresetn, // Sync reset, low
  input logic bit_stb, // Bit present
  input logic bit_val, // Bit value
  output logic viol_q // Violation seen
);
  logic [7:0] age_q [NMAX];
  logic [7:0] age_d [NMAX];
  logic [NMAX-1:0] sparse;
  logic [4:0] zc_q;
  logic [4:0] zc_d;

  // Ages of the most recent ones; N-th one too old means a sparse window
  genvar i;
  generate
    for (i = 0; i < NMAX; i++)
    begin : g_age
      if (i == 0)
      begin : g_first
        assign age_d[i] = bit_val ? 8'h00 :
          ((age_q[i] == 8'hff) ? 8'hff : 8'(age_q[i] + 8'h01));
      end
      else
      begin : g_rest
        assign age_d[i] = bit_val ?
          ((age_q[i-1] == 8'hff) ? 8'hff : 8'(age_q[i-1] + 8'h01)) :
          ((age_q[i] == 8'hff) ? 8'hff : 8'(age_q[i] + 8'h01));
      end
      assign sparse[i] = age_d[i] >= 8'(8 * (i + 2));
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          age_q[i] <= 8'h00;
        else if (bit_stb)
          age_q[i] <= age_d[i];
      end
    end
  endgenerate

  assign zc_d = bit_val ? 5'h00 : ((zc_q == 5'h1f) ? zc_q : 5'(zc_q + 5'h01));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      zc_q <= 5'h00;
      viol_q <= 1'b0;
    end
    else
    begin
      if (bit_stb)
        zc_q <= zc_d;
      viol_q <= bit_stb && ((zc_d > PD_MAXZ) || (|sparse));
    end
  end
endmodule

module t1m_top
  import t1m_pkg::*;
#(
  parameter int BLUE_CYC = BLUE_WIN_CYC
) (
  input logic aclk, // Clock, 10 MHz
  input logic aresetn, // Sync reset, low
  input logic [7:0] awaddr, // AXI write address
  input logic awvalid, // AXI
  output logic awready, // AXI
  input logic [31:0] wdata, // AXI write data
  input logic [3:0] wstrb, // AXI byte lanes
  input logic wvalid, // AXI
  output logic wready, // AXI
  output logic [1:0] bresp, // AXI
  output logic bvalid, // AXI
  input logic bready, // AXI
  input logic [7:0] araddr, // AXI read address
  input logic arvalid, // AXI
  output logic arready, // AXI
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI
  output logic rvalid, // AXI
  input logic rready, // AXI
  input logic rx_bit_stb, // Receive line bit present
  input logic rx_pos, // Positive mark
  input logic rx_neg, // Negative mark
  input logic tx_bit_stb, // Transmit bit present
  input logic tx_bit, // Transmit bit value
  input logic fbit_stb, // Ft or FPS bit received
  input logic fbit_err, // That bit was wrong
  input logic resync_stb, // Resync finished
  input logic resync_moved, // Alignment differs from before
  input logic fs12_stb, // Twelfth F bit received
  input logic fs12_val, // Its value
  input logic ch_stb, // Receive channel byte present
  input logic [4:0] ch_num, // Channel 0..23
  input logic [7:0] ch_byte, // Channel byte, MSB is bit 1
  input logic fdl_stb, // Data link bit present
  input logic fdl_bit, // Data link bit value
  input logic loss_of_frame_flag, // Framer out of frame
  output logic bp_valid, // Backplane byte present
  output logic [4:0] bp_num, // Backplane channel
  output logic [7:0] bp_byte, // Backplane byte
  output logic blue_alarm_flag, // Blue alarm
  output logic yellow_alarm_flag, // Yellow alarm
  output logic red_alarm_flag, // Red alarm, carrier loss
  output logic irq // Unmasked event pending
);
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] mw1_q, mw2_q, mw3_q, mask_q;
  logic [1:0] ctrl_q;
  t1m_evt_type evt_q, evt_set;
  logic [7:0] evt_d;
  t1m_alarm_type alrm;
  logic irq_q;

  // Register bus decode
  wire aw_hs = awvalid && awready_q;
  wire ar_hs = arvalid && arready_q;
  wire [5:0] wr_idx = awaddr[7:2];
  wire [5:0] rd_idx = araddr[7:2];
  wire wr_map = (awaddr[1:0] == 2'h0) && (wr_idx == IDX_MW1 || wr_idx == IDX_MW2 ||
    wr_idx == IDX_MW3 || wr_idx == IDX_EVT || wr_idx == IDX_MASK ||
    wr_idx == IDX_CTRL || wr_idx == IDX_ALRM);
  wire we = aw_hs && wr_map && wstrb[0];
  wire [7:0] evt_clr = (we && wr_idx == IDX_EVT) ? wdata[7:0] : 8'h00;
  wire rd_map = (araddr[1:0] == 2'h0) && (rd_idx == IDX_MW1 || rd_idx == IDX_MW2 ||
    rd_idx == IDX_MW3 || rd_idx == IDX_EVT || rd_idx == IDX_MASK ||
    rd_idx == IDX_CTRL || rd_idx == IDX_ALRM);
  wire [7:0] rd_mux = !rd_map ? 8'h00 :
    (rd_idx == IDX_MW1) ? mw1_q :
    (rd_idx == IDX_MW2) ? mw2_q :
    (rd_idx == IDX_MW3) ? mw3_q :
    (rd_idx == IDX_EVT) ? evt_q :
    (rd_idx == IDX_MASK) ? mask_q :
    (rd_idx == IDX_CTRL) ? {6'h00, ctrl_q} : {4'h0, alrm};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      awready_q <= !awready_q && awvalid && wvalid && !bvalid_q;
      wready_q <= !awready_q && awvalid && wvalid && !bvalid_q;
      if (aw_hs)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid_q <= 1'b0;
      arready_q <= !arready_q && arvalid && !rvalid_q;
      if (ar_hs)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= {24'h00_0000, rd_mux};
      end
      else if (rready)
        rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mw1_q <= RST_REG;
      mw2_q <= RST_REG;
      mw3_q <= RST_REG;
      mask_q <= RST_REG;
      ctrl_q <= 2'h0;
    end
    else if (we)
    begin
      if (wr_idx == IDX_MW1)
        mw1_q <= wdata[7:0];
      if (wr_idx == IDX_MW2)
        mw2_q <= wdata[7:0];
      if (wr_idx == IDX_MW3)
        mw3_q <= wdata[7:0];
      if (wr_idx == IDX_MASK)
        mask_q <= wdata[7:0];
      if (wr_idx == IDX_CTRL)
        ctrl_q <= wdata[1:0];
    end
  end

  // Milliwatt substitution; pattern steps once per frame for a 1 kHz tone
  logic [2:0] pat_q;
  logic bp_valid_q;
  logic [4:0] bp_num_q;
  logic [7:0] bp_byte_q;
  wire [23:0] mw_en = {mw3_q, mw2_q, mw1_q};
  wire mw_sel = (ch_num <= LAST_CH) && mw_en[ch_num];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pat_q <= 3'h0;
      bp_valid_q <= 1'b0;
      bp_num_q <= 5'h00;
      bp_byte_q <= 8'h00;
    end
    else
    begin
      bp_valid_q <= ch_stb;
      if (ch_stb)
      begin
        bp_num_q <= ch_num;
        bp_byte_q <= mw_sel ? MW_PAT[pat_q] : ch_byte;
        if (ch_num == LAST_CH)
          pat_q <= 3'(pat_q + 3'h1);
      end
    end
  end

  // Receive line: zero runs and B8ZS codewords
  logic [7:0] rz_q, pos_q, neg_q;
  logic pol_q;
  wire rx_zero = !rx_pos && !rx_neg;
  wire [7:0] rz_d = !rx_zero ? 8'h00 : ((rz_q == 8'hff) ? rz_q : 8'(rz_q + 8'h01));
  wire [7:0] pos_d = {pos_q[6:0], rx_pos};
  wire [7:0] neg_d = {neg_q[6:0], rx_neg};
  wire pol_now = pos_q[7] ? 1'b1 : (neg_q[7] ? 1'b0 : pol_q);
  wire b8_hit = pol_now ? (pos_d == B8_PRI && neg_d == B8_ALT) :
    (neg_d == B8_PRI && pos_d == B8_ALT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rz_q <= 8'h00;
      pos_q <= 8'h00;
      neg_q <= 8'h00;
      pol_q <= 1'b0;
    end
    else if (rx_bit_stb)
    begin
      rz_q <= rz_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
      pol_q <= pol_now;
    end
  end

  // Framing bit errors over the last six
  logic [5:0] fe_q;
  wire [5:0] fe_d = {fe_q[4:0], fbit_err};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fe_q <= 6'h00;
    else if (fbit_stb)
      fe_q <= fe_d;
  end

  logic tx_viol, rx_viol;

  t1m_pdv #(
    .NMAX(PD_NMAX)
  ) u_tx_pdv (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_stb(tx_bit_stb),
    .bit_val(tx_bit),
    .viol_q(tx_viol)
  );

  t1m_pdv #(
    .NMAX(PD_NMAX)
  ) u_rx_pdv (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_stb(rx_bit_stb),
    .bit_val(!rx_zero),
    .viol_q(rx_viol)
  );

  always_comb
  begin
    evt_set.framing_bit_error_evt = fbit_stb && fbit_err;
    evt_set.b8zs = rx_bit_stb && b8_hit;
    evt_set.severe_framing_err_evt = fbit_stb && ($countones(fe_d) >= 2);
    evt_set.z16 = rx_bit_stb && (rz_d == ZRUN_16);
    evt_set.z8 = rx_bit_stb && (rz_d == ZRUN_8);
    evt_set.alignment_change_evt = resync_stb && resync_moved;
    evt_set.tx_density_violation_evt = tx_viol;
    evt_set.rx_density_violation_evt = rx_viol;
  end

  // Set wins over a simultaneous write-one clear
  assign evt_d = (evt_q & ~evt_clr) | evt_set;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      evt_q <= RST_REG;
      irq_q <= 1'b0;
    end
    else
    begin
      evt_q <= evt_d;
      irq_q <= |(evt_d & mask_q);
    end
  end

  // Blue alarm: zeros counted over a fixed window tolerate sparse errors
  logic [31:0] bl_cnt_q;
  logic [2:0] bz_q;
  logic blue_q;
  wire bz_inc = rx_bit_stb && rx_zero;
  wire [2:0] bz_now = (bz_q > BLUE_MAXZ) ? bz_q : 3'(bz_q + {2'h0, bz_inc});
  wire bl_end = bl_cnt_q == 32'(BLUE_CYC - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bl_cnt_q <= 32'h0000_0000;
      bz_q <= 3'h0;
      blue_q <= 1'b0;
    end
    else
    begin
      bl_cnt_q <= bl_end ? 32'h0000_0000 : 32'(bl_cnt_q + 32'h0000_0001);
      bz_q <= bl_end ? 3'h0 : bz_now;
      if (bl_end)
        blue_q <= bz_now <= BLUE_MAXZ;
    end
  end

  // Yellow alarm in its three forms
  logic [7:0] ych_q;
  logic [8:0] yz_q;
  logic yel_b2_q, f12_prev_q, yel_f12_q;
  wire [8:0] yz_now = 9'(yz_q + {8'h00, !ch_byte[6]});

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ych_q <= 8'h00;
      yz_q <= 9'h000;
      yel_b2_q <= 1'b0;
      f12_prev_q <= 1'b0;
      yel_f12_q <= 1'b0;
    end
    else
    begin
      if (ch_stb)
      begin
        ych_q <= 8'(ych_q + 8'h01);
        yz_q <= (ych_q == 8'hff) ? 9'h000 : yz_now;
        if (ych_q == 8'hff)
          yel_b2_q <= yz_now >= YEL_MIN;
      end
      if (fs12_stb)
      begin
        f12_prev_q <= fs12_val;
        if (fs12_val && f12_prev_q)
          yel_f12_q <= 1'b1;
        else if (!fs12_val && !f12_prev_q)
          yel_f12_q <= 1'b0;
      end
    end
  end

  logic [15:0] fs_q;
  logic [3:0] fbit_q, fblk_q;
  logic [4:0] frun_q, fwin_q;
  logic falign_q, yel_esf_q;
  wire [15:0] fs_d = {fs_q[14:0], fdl_bit};
  wire fmatch = fs_d == FDL_PAT;
  wire fdone = fdl_stb && falign_q && (fbit_q == 4'hf);
  wire [4:0] fwin_now = 5'(fwin_q + {4'h0, fmatch});

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fs_q <= 16'h0000;
      fbit_q <= 4'h0;
      fblk_q <= 4'h0;
      frun_q <= 5'h00;
      fwin_q <= 5'h00;
      falign_q <= 1'b0;
      yel_esf_q <= 1'b0;
    end
    else if (fdl_stb)
    begin
      fs_q <= fs_d;
      fbit_q <= 4'(fbit_q + 4'h1);
      if (!falign_q && fmatch)
      begin
        falign_q <= 1'b1;
        fbit_q <= 4'h0;
        fblk_q <= 4'h1;
        frun_q <= 5'h01;
        fwin_q <= 5'h01;
      end
      else if (fdone)
      begin
        frun_q <= fmatch ? ((frun_q == FDL_RUN) ? frun_q : 5'(frun_q + 5'h01)) : 5'h00;
        fblk_q <= 4'(fblk_q + 4'h1);
        fwin_q <= (fblk_q == 4'hf) ? 5'h00 : fwin_now;
        if (fmatch && frun_q == 5'(FDL_RUN - 5'h01))
          yel_esf_q <= 1'b1;
        else if (fblk_q == 4'hf && fwin_now <= FDL_CLR_MAX)
          yel_esf_q <= 1'b0;
        if (!fmatch && !yel_esf_q)
          falign_q <= 1'b0;
      end
    end
  end

  // Red alarm: carrier loss and the ones-density recovery check
  t1m_red_type red_st_q;
  logic [6:0] rwin_q;
  logic [3:0] rones_q;
  wire [6:0] rwin_now = 7'(rwin_q + 7'h01);
  wire [3:0] rones_now = 4'(rones_q + {3'h0, !rx_zero});

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      red_st_q <= RED_OK;
      rwin_q <= 7'h00;
      rones_q <= 4'h0;
    end
    else if (rx_bit_stb)
    begin
      case (red_st_q)
        RED_OK:
          if (rz_d == RED_SET)
            red_st_q <= RED_LOST;
        RED_LOST:
          if (!rx_zero)
          begin
            red_st_q <= RED_CHK;
            rwin_q <= 7'h01;
            rones_q <= 4'h1;
          end
        RED_CHK:
        begin
          rwin_q <= rwin_now;
          rones_q <= rones_now;
          if (rones_now >= RED_ONES)
            red_st_q <= RED_OK;
          else if (rwin_now == RED_WIN)
            red_st_q <= RED_LOST;
        end
        default:
          red_st_q <= RED_OK;
      endcase
    end
  end

  logic blue_o_q, yel_o_q, red_o_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      blue_o_q <= 1'b0;
      yel_o_q <= 1'b0;
      red_o_q <= 1'b0;
    end
    else
    begin
      blue_o_q <= blue_q;
      yel_o_q <= ctrl_q[CTRL_ESF] ? yel_esf_q :
        (ctrl_q[CTRL_F12] ? yel_f12_q : yel_b2_q);
      red_o_q <= red_st_q != RED_OK;
    end
  end

  // Loss of frame sits in bit 3 of the alarm register, blue in bit 0, so software can qualify it
  assign alrm = '{lof: loss_of_frame_flag, red: red_o_q, yellow: yel_o_q,
                  blue: blue_o_q};

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign bp_valid = bp_valid_q;
  assign bp_num = bp_num_q;
  assign bp_byte = bp_byte_q;
  assign blue_alarm_flag = blue_o_q;
  assign yellow_alarm_flag = yel_o_q;
  assign red_alarm_flag = red_o_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_mw_in;
    ch_stb && mw_sel;
  endsequence
  property p_mw;
    s_mw_in |=> bp_valid && bp_byte == MW_PAT[$past(pat_q)];
  endproperty
  a_mw: assert property (p_mw) else $error("milliwatt byte wrong");
  property p_pass;
    ch_stb && !mw_sel |=> bp_byte == $past(ch_byte);
  endproperty
  a_pass: assert property (p_pass) else $error("byte altered");
  property p_fbe;
    fbit_stb && fbit_err |=> evt_q.framing_bit_error_evt;
  endproperty
  a_fbe: assert property (p_fbe) else $error("framing error lost");
  property p_z8;
    rx_bit_stb && rx_zero && rz_q == 8'h07 |=> evt_q.z8 ##1 irq == mask_q[4];
  endproperty
  a_z8: assert property (p_z8) else $error("eight zero missed");
  property p_z16;
    rx_bit_stb && rx_zero && rz_q == 8'h0f |=> evt_q.z16;
  endproperty
  a_z16: assert property (p_z16) else $error("sixteen zero missed");
  property p_alignment_change_evt;
    resync_stb && resync_moved |=> evt_q.alignment_change_evt;
  endproperty
  a_alignment_change_evt: assert property (p_alignment_change_evt) else $error("alignment change lost");
  sequence s_red_trip;
    red_st_q == RED_OK && rx_bit_stb && rx_zero && rz_q == 8'hbf;
  endsequence
  property p_red;
    s_red_trip |=> ##1 red_alarm_flag;
  endproperty
  a_red: assert property (p_red) else $error("red alarm late");
  property p_sticky;
    evt_q.severe_framing_err_evt && !evt_clr[2] |=> evt_q.severe_framing_err_evt;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  // Second one in a row of the twelfth F bit
  sequence s_f12_pair;
    fs12_stb && fs12_val && f12_prev_q;
  endsequence
  property p_f12;
    s_f12_pair |=> yel_f12_q;
  endproperty
  a_f12: assert property (p_f12) else $error("f12 yellow not set");
endmodule
